// file: alias_remap_defines.vh
// Register offsets, field layout and reset values of the alias remap block.
// Included by the remap datapath and its address match helper.
`ifndef ALIAS_REMAP_DEFINES_VH
`define ALIAS_REMAP_DEFINES_VH
`define REG_CONFIG           8'h03
`define REG_REMOTE_DES_ADDR  8'h06
`define REG_DES_ALIAS        8'h07
`define REG_REMOTE_TGT_ADDR  8'h08
`define REG_TGT_ALIAS        8'h09
`define CFG_PASS_THRU_BIT    2
`define AUTOLOAD_HOLD_BIT    0
`define ADDR_RESET           7'h00
`define CONFIG_RESET         8'h00
`define ROUTE_NONE           2'h0
`define ROUTE_DES            2'h1
`define ROUTE_TGT            2'h2
`endif

// file: alias_match.v
// Compares one incoming 7-bit address against one alias field.
// Assumes the alias is a register on the same clock; a zero alias never hits.
`timescale 1ns/100ps
`include "alias_remap_defines.vh"
module alias_match (
	input  wire [6:0] addr_in,   // Address of the local transaction
	input  wire [6:0] alias_id,  // Stored alias
	input  wire [6:0] remap_id,  // Address to forward to on a hit
	output wire       hit,       // Alias is nonzero and matches the address
	output wire [6:0] remap_out  // Remapped address
);
	assign hit = (alias_id != `ADDR_RESET) && (addr_in == alias_id);
	assign remap_out = remap_id;
endmodule // alias_match

// file: i2c_alias_remap.v
// Alias decode and address remap for forwarded control-bus transactions,
// plus the register bank that holds the aliases and remote addresses.
// Assumes a local control-bus front end on clk_sys that presents each
// transaction's 7-bit address with a one-cycle strobe, and a back-channel
// block on clk_sys that delivers the autoloaded remote deserializer address.
// The register side is a plain strobe bus; read data is registered.
// Every flop is on clk_sys, and clk_en low freezes all of them.
//
// How it works
// - Deserializer alias in bits 7:1; matching transactions are accepted.
// - Deserializer-alias hits forward to the remote deserializer address.
// - A zero deserializer alias blocks all access to the remote deserializer.
// - Target-alias hits are remapped and sent over the channel.
// - Target alias in bits 7:1; matches remap to the target address.
// - Zero target address or zero target alias blocks the remote target.
// - Target address field in bits 7:1, read/write, reset to zero.
// - Remote deserializer address autoloads on lock unless hold bit is set.
// - Forwarding happens only while the pass-through enable bit is one.
`timescale 1ns/100ps
`include "alias_remap_defines.vh"
module i2c_alias_remap (
	input  wire       clk_sys,      // System clock, 50 MHz
	input  wire       rst,          // Synchronous reset, active high
	input  wire       clk_en,       // Freezes all state while low
	input  wire       reg_wr,       // Register write strobe
	input  wire       reg_rd,       // Register read strobe
	input  wire [7:0] reg_addr,     // Register offset
	input  wire [7:0] reg_wdata,    // Register write data
	output reg  [7:0] reg_rdata,    // Register read data
	input  wire       rx_lock,      // Receive lock from the link
	input  wire       autoload_vld, // Address from back channel valid
	input  wire [6:0] autoload_id,  // Address from back channel
	input  wire       txn_start,    // Local transaction address strobe
	input  wire [6:0] txn_addr,     // Local transaction target address
	output reg        fwd_vld,      // Forward request, one cycle
	output reg  [6:0] fwd_addr,     // Remapped address to forward
	output reg  [1:0] fwd_route,    // Which remote path was taken
	output reg        txn_accept    // Transaction accepted, one cycle
);
	reg  [7:0] config_ff;
	reg  [6:0] des_addr_ff;
	reg        hold_ff;
	reg  [6:0] des_alias_ff;
	reg  [6:0] tgt_addr_ff;
	reg  [6:0] tgt_alias_ff;
	reg        lock_s1_ff;
	reg        lock_s2_ff;
	wire       des_hit;
	wire       tgt_hit_raw;
	wire       tgt_hit;
	wire [6:0] des_remap;
	wire [6:0] tgt_remap;
	wire       pass_en;
	reg        nxt_fwd_vld;
	reg  [6:0] nxt_fwd_addr;
	reg  [1:0] nxt_fwd_route;
	reg  [7:0] nxt_reg_rdata;

	function wr_hit;
		input [7:0] off;
		begin
			wr_hit = reg_wr && (reg_addr == off);
		end
	endfunction

	function [7:0] field_rd;
		input [6:0] field;
		begin
			field_rd = {field, 1'b0};
		end
	endfunction

	function addr_set;
		input [6:0] id;
		begin
			addr_set = (id != `ADDR_RESET);
		end
	endfunction

	// Lock is asynchronous to clk_sys
	// Two stages; only the second one feeds any logic.
	always @(posedge clk_sys) begin
		if (rst) begin
			lock_s1_ff <= 1'b0;
			lock_s2_ff <= 1'b0;
		end else if (clk_en) begin
			lock_s1_ff <= rx_lock;
			lock_s2_ff <= lock_s1_ff;
		end
	end

	// A transaction on the same edge still matches the old alias.
	// alias, target address and config storage
	always @(posedge clk_sys) begin
		if (rst) begin
			config_ff    <= `CONFIG_RESET;
			des_alias_ff <= `ADDR_RESET;
			tgt_addr_ff  <= `ADDR_RESET;
			tgt_alias_ff <= `ADDR_RESET;
		end else if (clk_en) begin
			if (wr_hit(`REG_CONFIG))
				config_ff <= reg_wdata;
			if (wr_hit(`REG_DES_ALIAS))
				des_alias_ff <= reg_wdata[7:1];
			if (wr_hit(`REG_REMOTE_TGT_ADDR))
				tgt_addr_ff <= reg_wdata[7:1];
			if (wr_hit(`REG_TGT_ALIAS))
				tgt_alias_ff <= reg_wdata[7:1];
		end
	end

	// autoload unless held
	// Software write wins over a same-cycle autoload so a held value sticks.
	// A pulse that arrives before lock settles is dropped, not queued.
	always @(posedge clk_sys) begin
		if (rst) begin
			des_addr_ff <= `ADDR_RESET;
			hold_ff     <= 1'b0;
		end else if (clk_en) begin
			if (wr_hit(`REG_REMOTE_DES_ADDR)) begin
				des_addr_ff <= reg_wdata[7:1];
				hold_ff     <= reg_wdata[`AUTOLOAD_HOLD_BIT];
			end else if (autoload_vld && lock_s2_ff && !hold_ff) begin
				des_addr_ff <= autoload_id;
			end
		end
	end

	always @* begin
		nxt_reg_rdata = 8'h00;
		case (reg_addr)
		`REG_CONFIG:
			nxt_reg_rdata = config_ff;
		// Hold bit reads back so software sees the freeze
		`REG_REMOTE_DES_ADDR:
			nxt_reg_rdata = {des_addr_ff, hold_ff};
		`REG_DES_ALIAS:
			nxt_reg_rdata = field_rd(des_alias_ff);
		`REG_REMOTE_TGT_ADDR:
			nxt_reg_rdata = field_rd(tgt_addr_ff);
		`REG_TGT_ALIAS:
			nxt_reg_rdata = field_rd(tgt_alias_ff);
		// Unmapped offsets read zero
		default:
			nxt_reg_rdata = 8'h00;
		endcase
	end

	// Latched only on a read strobe; the byte stands until the next read
	always @(posedge clk_sys) begin
		if (rst)
			reg_rdata <= 8'h00;
		else if (clk_en && reg_rd)
			reg_rdata <= nxt_reg_rdata;
	end

	alias_match u_des_match (
		.addr_in   (txn_addr),
		.alias_id  (des_alias_ff),
		.remap_id  (des_addr_ff),
		.hit       (des_hit),
		.remap_out (des_remap)
	);

	alias_match u_tgt_match (
		.addr_in   (txn_addr),
		.alias_id  (tgt_alias_ff),
		.remap_id  (tgt_addr_ff),
		.hit       (tgt_hit_raw),
		.remap_out (tgt_remap)
	);

	// zero target address blocks
	// The zero-alias half of this rule sits inside the match helper.
	assign tgt_hit = tgt_hit_raw && addr_set(tgt_addr_ff);
	// One enable gates both paths; a disabled bridge drops every request.
	assign pass_en = config_ff[`CFG_PASS_THRU_BIT];

	// Deserializer alias takes priority if both aliases hold the same value.
	always @* begin
		nxt_fwd_vld   = 1'b0;
		nxt_fwd_addr  = fwd_addr;
		nxt_fwd_route = `ROUTE_NONE;
		if (txn_start && pass_en) begin
			if (des_hit) begin
				nxt_fwd_vld   = 1'b1;
				nxt_fwd_addr  = des_remap;
				nxt_fwd_route = `ROUTE_DES;
			end else if (tgt_hit) begin
				nxt_fwd_vld   = 1'b1;
				nxt_fwd_addr  = tgt_remap;
				nxt_fwd_route = `ROUTE_TGT;
			end
		end
	end

	// txn_accept mirrors fwd_vld as the acknowledge for the local front end.
	// fwd_addr keeps its last value between requests.
	always @(posedge clk_sys) begin
		if (rst) begin
			fwd_vld    <= 1'b0;
			fwd_addr   <= `ADDR_RESET;
			fwd_route  <= `ROUTE_NONE;
			txn_accept <= 1'b0;
		end else if (clk_en) begin
			fwd_vld    <= nxt_fwd_vld;
			fwd_addr   <= nxt_fwd_addr;
			fwd_route  <= nxt_fwd_route;
			txn_accept <= nxt_fwd_vld;
		end
	end
endmodule // i2c_alias_remap

// file: backchan_model.sv
// Back-channel model: link lock level and remote address autoload pulse.
// Driven only through calls of send from the bench.
`timescale 1ns/100ps
module backchan_model (
	input  wire       clk_sys,      // System clock
	output reg        rx_lock,      // Link lock level
	output reg        autoload_vld, // Address valid pulse
	output reg  [6:0] autoload_id   // Remote deserializer address
);
	initial begin
		rx_lock = 1'b0;
		autoload_vld = 1'b0;
		autoload_id = 7'h55;
	end
	// Id is inverted off the pulse so a stale value never passes as valid
	task send(input [6:0] id); begin
		@(posedge clk_sys) rx_lock <= 1'b1;
		repeat (3) @(posedge clk_sys);
		{autoload_vld, autoload_id} <= {1'b1, id};
		@(posedge clk_sys) {autoload_vld, autoload_id} <= {1'b0, ~id};
	end endtask
endmodule // backchan_model

// file: alias_remap_chk_sva.sv
// Port checker for the alias remap block.
// Assumes one clock and a synchronous reset.
`timescale 1ns/100ps
module alias_remap_chk (
	input wire logic       clk_sys,    // System clock
	input wire logic       rst,        // Synchronous reset
	input wire logic       clk_en,     // Clock enable
	input wire logic       reg_rd,     // Read strobe
	input wire logic [7:0] reg_addr,   // Register offset
	input wire logic [7:0] reg_rdata,  // Read data
	input wire logic       txn_start,  // Transaction strobe
	input wire logic [6:0] txn_addr,   // Transaction address
	input wire logic       fwd_vld,    // Forward pulse
	input wire logic [6:0] fwd_addr,   // Remapped address
	input wire logic [1:0] fwd_route,  // Path taken
	input wire logic       txn_accept  // Accept pulse
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (rst);
	sequence s_take;
		clk_en && txn_start;
	endsequence
	a_pulse_pair: assert property (
		txn_accept == fwd_vld) else $error("accept differs");
	a_fwd_cause: assert property (
		fwd_vld && $past(clk_en) |-> $past(txn_start)) else $error("cause");
	a_route_code: assert property (
		fwd_vld |-> fwd_route inside {2'h1, 2'h2}) else $error("route");
	a_zero_blocked: assert property (
		s_take ##0 txn_addr == 7'h00 |=> !fwd_vld) else $error("zero");
	a_tgt_nonzero: assert property (
		fwd_vld && fwd_route == 2'h2 |-> fwd_addr != 7'h00) else $error("tgt");
	a_addr_hold: assert property (
		!fwd_vld |-> $stable(fwd_addr)) else $error("addr moved");
	a_rsvd_zero: assert property (
		reg_rd && clk_en && reg_addr inside {8'h07, 8'h08, 8'h09}
		|=> !reg_rdata[0]) else $error("bit0");
	a_rdata_hold: assert property (
		!(reg_rd && clk_en) |=> $stable(reg_rdata)) else $error("rdata");
endmodule // alias_remap_chk
bind i2c_alias_remap alias_remap_chk u_chk (.*);

// file: i2c_alias_remap_bench.sv
// Bench: register access, autoload and alias forwarding tests.
// Assumes the back-channel model and the bound checker.
`timescale 1ns/100ps
module i2c_alias_remap_bench;
	reg clk_sys = 1'b0;
	reg rst = 1'b1;
	reg reg_wr = 1'b0, reg_rd = 1'b0, txn_start = 1'b0, clk_en = 1'b1;
	reg [7:0] reg_addr = 8'h00, reg_wdata = 8'h00;
	reg [6:0] txn_addr = 7'h00;
	wire [7:0] reg_rdata;
	wire rx_lock, autoload_vld, fwd_vld, txn_accept;
	wire [6:0] autoload_id, fwd_addr;
	wire [1:0] fwd_route;
	integer bad_count = 0, total_checks = 0, cyc = 0;
	always #10 clk_sys = ~clk_sys;
	backchan_model bc (.*);
	i2c_alias_remap dut (.*);
	task chk(input string nm, input [7:0] e, g); begin
		total_checks = total_checks + 1;
		if (g !== e) begin
			bad_count = bad_count + 1;
			$display("wrong value %0s exp %h got %h", nm, e, g);
		end
	end endtask
	task wr(input [7:0] a, d); begin
		@(posedge clk_sys) {reg_wr, reg_addr, reg_wdata} <= {1'b1, a, d};
		@(posedge clk_sys) reg_wr <= 1'b0;
	end endtask
	task rd(input [7:0] a, e); begin
		@(posedge clk_sys) {reg_rd, reg_addr} <= {1'b1, a};
		@(posedge clk_sys) reg_rd <= 1'b0;
		#1 chk("rdata", e, reg_rdata);
	end endtask
	task tx(input [6:0] a, input v, input [6:0] ea, input [1:0] r); begin
		@(posedge clk_sys) {txn_start, txn_addr} <= {1'b1, a};
		@(posedge clk_sys) txn_start <= 1'b0;
		#1 chk("fwd_vld", {7'h0, v}, {7'h0, fwd_vld});
		chk("txn_accept", {7'h0, v}, {7'h0, txn_accept});
		if (v) begin
			chk("fwd_addr", {1'b0, ea}, {1'b0, fwd_addr});
			chk("fwd_route", {6'h0, r}, {6'h0, fwd_route});
		end
	end endtask
	task wrap_up; begin
		$display("checks %0d mismatches %0d", total_checks, bad_count);
		if (bad_count == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	end endtask
	always @(posedge clk_sys) begin
		cyc = cyc + 1;
		if (cyc == 2000) begin
			bad_count = bad_count + 1;
			wrap_up;
		end
	end
	initial begin
		repeat (8) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'h07, 8'h00);
		rd(8'h08, 8'h00);
		rd(8'h09, 8'h00);
		wr(8'h07, 8'h85);
		rd(8'h07, 8'h84);
		wr(8'h05, 8'hff);
		rd(8'h05, 8'h00);
		$display("registers test done");
		bc.send(7'h33);
		rd(8'h06, 8'h66);
		wr(8'h06, 8'h43);
		bc.send(7'h55);
		rd(8'h06, 8'h43);
		$display("autoload test done");
		tx(7'h42, 1'b0, 7'h00, 2'h0);
		wr(8'h03, 8'h04);
		tx(7'h42, 1'b1, 7'h21, 2'h1);
		wr(8'h09, 8'h51);
		tx(7'h28, 1'b0, 7'h00, 2'h0);
		wr(8'h08, 8'h61);
		rd(8'h08, 8'h60);
		tx(7'h28, 1'b1, 7'h30, 2'h2);
		@(posedge clk_sys) clk_en <= 1'b0;
		tx(7'h28, 1'b0, 7'h00, 2'h0);
		wr(8'h07, 8'h00);
		@(posedge clk_sys) clk_en <= 1'b1;
		rd(8'h07, 8'h84);
		$display("freeze test done");
		wr(8'h09, 8'h00);
		tx(7'h28, 1'b0, 7'h00, 2'h0);
		wr(8'h07, 8'h00);
		tx(7'h42, 1'b0, 7'h00, 2'h0);
		tx(7'h00, 1'b0, 7'h00, 2'h0);
		$display("forwarding test done");
		wrap_up;
	end
endmodule // i2c_alias_remap_bench
